/* File: core/cslbc_pkg.sv */
// Package: register map, field layout, reset values and encodings of the local bus controller
`default_nettype none
package cslbc_pkg;
  // Register byte offsets
  localparam logic [11:0] CSLBC_OFS_BOOT   = 12'h300;
  localparam logic [11:0] CSLBC_OFS_CFG1   = 12'h304;
  localparam logic [11:0] CSLBC_OFS_CFG5   = 12'h314;
  localparam logic [11:0] CSLBC_OFS_CTRL   = 12'h318;
  localparam logic [11:0] CSLBC_OFS_STAT   = 12'h31c;
  // Config fields, bit 0 = lsb (printed msb-first numbering mirrored)
  localparam int CSLBC_F_RO     = 0;
  localparam int CSLBC_F_WO     = 1;
  localparam int CSLBC_F_RS     = 2;
  localparam int CSLBC_F_WS     = 3;
  localparam int CSLBC_F_WAIT_TYPE_FIELD   = 4;
  localparam int CSLBC_F_BANK   = 6;
  localparam int CSLBC_F_DS     = 8;
  localparam int CSLBC_F_AS     = 10;
  localparam int CSLBC_F_CE     = 12;
  localparam int CSLBC_F_AA     = 13;
  localparam int CSLBC_F_AL     = 14;
  localparam int CSLBC_F_MX     = 15;
  localparam int CSLBC_F_WAITX  = 16;
  localparam int CSLBC_F_WAITP  = 24;
  // Control register: master enable, bus error enable, interrupt enable
  localparam int CSLBC_C_ME     = 24;
  localparam int CSLBC_C_IE     = 8;
  localparam int CSLBC_C_EBEE   = 0;
  // Status register: sticky violation flag, write one to clear
  localparam int CSLBC_S_VIOL   = 24;
  // Reset values: boot space read-only and enabled, others off
  localparam logic [31:0] CSLBC_BOOT_RST = 32'h0000_1001;
  localparam logic [31:0] CSLBC_CFG_RST  = 32'h0000_0000;
  localparam logic [31:0] CSLBC_CTRL_RST = 32'h0000_0000;
  // Wait type encodings
  localparam logic [1:0] CSLBC_WT_SAME  = 2'h0;
  localparam logic [1:0] CSLBC_WT_SPLIT = 2'h1;
  localparam logic [1:0] CSLBC_WT_LONGW = 2'h2;
  localparam logic [1:0] CSLBC_WT_LONG  = 2'h3;
  // Data size encodings and size codes on the address tenure
  localparam logic [1:0] CSLBC_DS_1B    = 2'h0;
  localparam logic [1:0] CSLBC_DS_2B    = 2'h1;
  localparam logic [1:0] CSLBC_DS_3B    = 2'h2;
  localparam logic [2:0] CSLBC_TSZ_1    = 3'h1;
  localparam logic [2:0] CSLBC_TSZ_2    = 3'h2;
  localparam logic [2:0] CSLBC_TSZ_4    = 3'h4;
  // Address tenure line positions
  localparam int CSLBC_AD_TSZ   = 28;
  localparam int CSLBC_AD_BANK  = 25;
  localparam int CSLBC_ADDR_W   = 25;
  // Chip select count
  localparam int CSLBC_NCS      = 6;
endpackage
`default_nettype wire

/* File: core/cslbc_ctrl.sv */
// Local bus controller: slave register file, chip-select transaction engine
`default_nettype none
module cslbc_ctrl
  import cslbc_pkg::*;
#(
  parameter int WAIT_W = 16
) (
  // Clock and reset
  input  wire  logic        clock,
  input  wire  logic        rst,
  // Internal peripheral bus slave: register side
  input  wire  logic        reg_sel,
  input  wire  logic        reg_wr,
  input  wire  logic [11:0] reg_addr,
  input  wire  logic [31:0] reg_wdata,
  output var   logic [31:0] reg_rdata,
  output var   logic        reg_ack,
  // Internal peripheral bus slave: external access side (memory map hit)
  input  wire  logic        xs_req,
  input  wire  logic [2:0]  xs_cs,
  input  wire  logic        xs_wr,
  input  wire  logic [24:0] xs_addr,
  input  wire  logic [3:0]  xs_be,
  input  wire  logic [31:0] xs_wdata,
  output var   logic [31:0] xs_rdata,
  output var   logic        xs_ack,
  output var   logic        core_transfer_error_ack,
  // Shared address/data bus
  input  wire  logic [31:0] ad_in,
  output var   logic [31:0] ad_out,
  output var   logic [31:0] ad_oe,
  output var   logic        bus_busy,
  // Control pins
  output var   logic [5:0]  cs_n,
  output var   logic        read_write_n,
  output var   logic        ale_n,
  output var   logic        transfer_start_strobe_n,
  input  wire  logic        ack_n,
  output var   logic        viol_irq
);

  initial begin
    if (WAIT_W != 16) $error("cslbc_ctrl: WAIT_W must be 16");
  end

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_DEAD = 6'h04,
    ST_DATA = 6'h08,
    ST_HOLD = 6'h10,
    ST_DONE = 6'h20
  } cslbc_state_t;

  typedef struct packed {
    cslbc_state_t     st;
    logic [5:0][31:0] cfg;
    logic [31:0]      ctrl;
    logic             viol;
    logic [31:0]      rdata;
    logic             rack;
    logic [31:0]      xrd;
    logic             xack;
    logic             xerr;
    logic [31:0]      ad;
    logic [31:0]      oe;
    logic             busy;
    logic [5:0]       csn;
    logic             rwn;
    logic             alen;
    logic             tsn;
    logic [WAIT_W-1:0] cnt;
    logic             alecnt;
    logic             irq;
    logic [1:0]       ack_sync;
  } cslbc_reg_t;

  cslbc_reg_t r_q;
  cslbc_reg_t r_d;

  // Current chip-select config and decoded fields
  logic [31:0]       cur;
  logic [1:0]        ds;
  logic [WAIT_W-1:0] wcount;
  logic [31:0]       wswap;
  logic [31:0]       data_lanes;
  logic [2:0]        tsz;
  logic [2:0]        rsel;
  logic              reg_hit;
  logic              forbid;

  // Byte reverse over the transfer size, shared by both directions
  function automatic logic [31:0] swap_bytes(input logic [31:0] v, input logic [2:0] sz);
    logic [31:0] o;
    o = v;
    if (sz == CSLBC_TSZ_2) o = {16'h0000, v[7:0], v[15:8]};
    else if (sz == CSLBC_TSZ_4) o = {v[7:0], v[15:8], v[23:16], v[31:24]};
    return o;
  endfunction

  always_comb begin
    cur = r_q.cfg[xs_cs];
    ds  = cur[CSLBC_F_DS +: 2];
    // Size code from byte enables; others are invalid and treated as one byte
    case (xs_be)
      4'h3, 4'hc: tsz = CSLBC_TSZ_2;
      4'hf:       tsz = CSLBC_TSZ_4;
      default:    tsz = CSLBC_TSZ_1;
    endcase
    // Wait count selection per wait type field
    case (cur[CSLBC_F_WAIT_TYPE_FIELD +: 2])
      CSLBC_WT_SAME:  wcount = {8'h00, cur[CSLBC_F_WAITX +: 8]};
      CSLBC_WT_SPLIT: wcount = xs_wr ? {8'h00, cur[CSLBC_F_WAITP +: 8]}
                                     : {8'h00, cur[CSLBC_F_WAITX +: 8]};
      CSLBC_WT_LONGW: wcount = xs_wr ? cur[CSLBC_F_WAITX +: 16]
                                     : {8'h00, cur[CSLBC_F_WAITX +: 8]};
      default:        wcount = cur[CSLBC_F_WAITX +: 16];
    endcase
    wswap = cur[CSLBC_F_WS] ? swap_bytes(xs_wdata, tsz) : xs_wdata;
    // Lanes the peripheral may drive: multiplexed at bottom, plain at top
    case (ds)
      CSLBC_DS_1B: data_lanes = cur[CSLBC_F_MX] ? 32'h0000_00ff : 32'hff00_0000;
      CSLBC_DS_2B: data_lanes = cur[CSLBC_F_MX] ? 32'h0000_ffff : 32'hffff_0000;
      default:     data_lanes = cur[CSLBC_F_MX] ? 32'hffff_ffff : 32'hffff_0000;
    endcase
    forbid  = (xs_wr && cur[CSLBC_F_RO]) || (!xs_wr && cur[CSLBC_F_WO]);
    reg_hit = reg_addr >= CSLBC_OFS_BOOT && reg_addr <= CSLBC_OFS_STAT
              && reg_addr[1:0] == 2'h0;
    rsel    = 3'((reg_addr - CSLBC_OFS_BOOT) >> 2);
  end

  // Next-state logic for the whole block
  always_comb begin
    r_d      = r_q;
    r_d.rack = 1'b0;
    r_d.xack = 1'b0;
    r_d.xerr = 1'b0;
    r_d.ack_sync = {r_q.ack_sync[0], ack_n};
    // Register access, answered one clock later
    if (reg_sel && !r_q.rack) begin
      r_d.rack  = 1'b1;
      r_d.rdata = 32'h0000_0000;
      if (!reg_hit) begin
        r_d.xerr = r_q.ctrl[CSLBC_C_EBEE];
      end else if (rsel < 3'(CSLBC_NCS)) begin
        r_d.rdata = r_q.cfg[rsel];
        if (reg_wr) r_d.cfg[rsel] = reg_wdata;
      end else if (reg_addr == CSLBC_OFS_CTRL) begin
        r_d.rdata = r_q.ctrl;
        if (reg_wr) r_d.ctrl = reg_wdata;
      end else begin
        r_d.rdata = {7'h00, r_q.viol, 24'h00_0000};
      end
    end
    // Write one clears the violation flag; a new violation below wins
    if (reg_sel && !r_q.rack && reg_wr && reg_addr == CSLBC_OFS_STAT
        && reg_wdata[CSLBC_S_VIOL]) begin
      r_d.viol = 1'b0;
    end
    case (r_q.st)
      ST_IDLE: begin
        r_d.busy = 1'b0;
        r_d.oe   = 32'h0000_0000;
        if (xs_req) begin
          if (forbid) begin
            // Never reaches the pins; status set regardless of enables
            r_d.viol = 1'b1;
            r_d.xerr = r_q.ctrl[CSLBC_C_EBEE];
            r_d.xack = 1'b1;
            r_d.st   = ST_DONE;
          end else if (!cur[CSLBC_F_CE] || (xs_cs != 3'h0 && !r_q.ctrl[CSLBC_C_ME])) begin
            r_d.xack = 1'b1;
            r_d.st   = ST_DONE;
          end else begin
            r_d.busy = 1'b1;
            r_d.rwn  = !xs_wr;
            r_d.cnt  = (wcount == '0) ? WAIT_W'(1) : wcount;
            r_d.oe   = 32'hffff_ffff;
            if (cur[CSLBC_F_MX]) begin
              // Whole bus driven; spare lines low
              r_d.ad = 32'h0000_0000;
              r_d.ad[CSLBC_ADDR_W-1:0] = xs_addr;
              r_d.ad[CSLBC_AD_BANK +: 2] = cur[CSLBC_F_BANK +: 2];
              r_d.ad[CSLBC_AD_TSZ +: 3] = tsz;
              r_d.alen   = 1'b0;
              r_d.alecnt = cur[CSLBC_F_AL];
              r_d.st     = ST_ADDR;
            end else begin
              // Address at the bottom, data msb on line 31
              r_d.ad = {xs_addr[15:0] & ~data_lanes[15:0], 16'h0000};
              r_d.ad = {16'h0000, xs_addr[15:0]} & ~data_lanes;
              if (xs_wr) begin
                r_d.ad = r_d.ad | ((ds == CSLBC_DS_1B) ? {wswap[7:0], 24'h00_0000}
                                                      : {wswap[15:0], 16'h0000});
              end else begin
                r_d.oe = ~data_lanes;
              end
              r_d.ad[23:16] = (ds == CSLBC_DS_1B) ? xs_addr[23:16] : r_d.ad[23:16];
              r_d.csn[xs_cs] = 1'b0;
              r_d.st = ST_DATA;
            end
          end
        end
      end
      ST_ADDR: begin
        if (r_q.alecnt) r_d.alecnt = 1'b0;
        else begin
          r_d.alen = 1'b1;
          r_d.st   = ST_DEAD;
        end
      end
      ST_DEAD: begin
        // Data tenure from line 0; unused lanes low, read lanes released
        r_d.ad  = xs_wr ? (wswap & data_lanes) : 32'h0000_0000;
        r_d.oe  = xs_wr ? 32'hffff_ffff : ~data_lanes;
        r_d.csn[xs_cs] = 1'b0;
        r_d.tsn = 1'b0;
        r_d.st  = ST_DATA;
      end
      ST_DATA: begin
        r_d.tsn = 1'b1;
        r_d.cnt = r_q.cnt - WAIT_W'(1);
        // Acknowledge can only cut the count short
        if (r_q.cnt == WAIT_W'(1) ||
            (cur[CSLBC_F_MX] && cur[CSLBC_F_AA] && !r_q.ack_sync[1])) begin
          r_d.csn = 6'h3f;
          r_d.xrd = cur[CSLBC_F_MX] ? (ad_in & data_lanes)
                  : ((ds == CSLBC_DS_1B) ? {24'h00_0000, ad_in[31:24]}
                                         : {16'h0000, ad_in[31:16]});
          if (cur[CSLBC_F_RS]) r_d.xrd = swap_bytes(r_d.xrd, tsz);
          r_d.st = ST_HOLD;
        end
      end
      ST_HOLD: begin
        // Signals held one clock past chip select, then bus released
        r_d.oe   = 32'h0000_0000;
        r_d.ad   = 32'h0000_0000;
        r_d.busy = 1'b0;
        r_d.xack = 1'b1;
        r_d.rwn  = 1'b1;
        r_d.st   = ST_DONE;
      end
      ST_DONE: begin
        // Wait for the request to drop so one access runs once
        if (!xs_req) r_d.st = ST_IDLE;
      end
      default: r_d.st = ST_IDLE;
    endcase
    r_d.irq = r_d.viol && r_q.ctrl[CSLBC_C_IE];
  end

  // Single state register
  always_ff @(posedge clock) begin
    if (rst) begin
      r_q          <= '0;
      r_q.st       <= ST_IDLE;
      r_q.cfg[0]   <= CSLBC_BOOT_RST;
      r_q.ctrl     <= CSLBC_CTRL_RST;
      r_q.csn      <= 6'h3f;
      r_q.rwn      <= 1'b1;
      r_q.alen     <= 1'b1;
      r_q.tsn      <= 1'b1;
      r_q.ack_sync <= 2'h3;
    end else begin
      r_q <= r_d;
    end
  end

  // Outputs straight from flops
  assign reg_rdata               = r_q.rdata;
  assign reg_ack                 = r_q.rack;
  assign xs_rdata                = r_q.xrd;
  assign xs_ack                  = r_q.xack;
  assign core_transfer_error_ack = r_q.xerr;
  assign ad_out                  = r_q.ad;
  assign ad_oe                   = r_q.oe;
  assign bus_busy                = r_q.busy;
  assign cs_n                    = r_q.csn;
  assign read_write_n            = r_q.rwn;
  assign ale_n                   = r_q.alen;
  assign transfer_start_strobe_n = r_q.tsn;
  assign viol_irq                = r_q.irq;

endmodule
`default_nettype wire

/* File: verif/cslbc_ctrl_chk.sv */
// Checker: pin timing relations of the local bus controller
`default_nettype none
module cslbc_ctrl_chk (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // Watched outputs
  input wire logic        xs_ack,
  input wire logic [31:0] ad_out,
  input wire logic [31:0] ad_oe,
  input wire logic        bus_busy,
  input wire logic [5:0]  cs_n,
  input wire logic        read_write_n,
  input wire logic        ale_n,
  input wire logic        transfer_start_strobe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Strobe lasts one or two clocks, never three
  a_ale_width: assert property ($fell(ale_n) |-> ##[1:2] $rose(ale_n))
    else $error("latch strobe width wrong");
  // Dead clock after the strobe, then select
  a_dead_cycle: assert property ($rose(ale_n) |-> (&cs_n) ##1 !(&cs_n))
    else $error("no dead cycle before select");
  a_addr_lines: assert property (!ale_n |-> ad_oe == 32'hffff_ffff && !ad_out[31] && !ad_out[27])
    else $error("address tenure lines wrong");
  a_one_select: assert property ($onehot0(~cs_n))
    else $error("several selects low");
  a_ts_start: assert property ($fell(transfer_start_strobe_n) |-> $fell(&cs_n) ##1 transfer_start_strobe_n)
    else $error("start strobe misplaced");
  a_rw_steady: assert property (bus_busy && $past(bus_busy) |-> $stable(read_write_n))
    else $error("direction changed in cycle");
  // Hold one clock past deselect, then let go of the bus
  a_hold_release: assert property ($rose(&cs_n) |-> $stable(ad_out & ad_oe) && $stable(ad_oe)
    && $stable(read_write_n) ##1 (ad_oe == 32'h0 && !bus_busy))
    else $error("hold or release wrong");
  a_ack_pulse: assert property (xs_ack |=> !xs_ack)
    else $error("answer longer than one clock");
  a_idle_quiet: assert property (!bus_busy |-> (&cs_n) && ad_oe == 32'h0)
    else $error("pins active while idle");
endmodule
bind cslbc_ctrl cslbc_ctrl_chk chk_u (.clock(clock), .rst(rst), .xs_ack(xs_ack),
  .ad_out(ad_out), .ad_oe(ad_oe), .bus_busy(bus_busy), .cs_n(cs_n),
  .read_write_n(read_write_n), .ale_n(ale_n), .transfer_start_strobe_n(transfer_start_strobe_n));
`default_nettype wire

/* File: verif/cslbc_periph.sv */
// Peripheral model: answers reads on the shared bus and may acknowledge
`default_nettype none
module cslbc_periph (
  // Clock
  input  wire logic        clock,
  // Pins from the controller
  input  wire logic [5:0]  cs_n,
  input  wire logic        read_write_n,
  input  wire logic [31:0] ad_out,
  input  wire logic [31:0] ad_oe,
  // Behaviour set by the bench
  input  wire logic [31:0] rd_val,
  input  wire logic [7:0]  ack_at,
  // Resolved bus and acknowledge
  output var  logic [31:0] ad_in,
  output var  logic        ack_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] last = 32'h0;
  logic [7:0]  n = 8'h0;
  logic        drv;
  // Drive only in a selected read, otherwise off the bus
  assign drv = !(&cs_n) && read_write_n;
  // Released lines toggle, so stale data never looks valid
  assign ad_in = (ad_oe & ad_out) | (~ad_oe & (drv ? rd_val : ~last));
  // Low from the chosen count until deselect; zero means never
  assign ack_n = !(ack_at != 8'h0 && n >= ack_at);
  always @(posedge clock) begin
    last <= ad_in;
    n <= (&cs_n) ? 8'h0 : n + 8'h1;
  end
endmodule
`default_nettype wire

/* File: verif/cslbc_ctrl_tb.sv */
// Testbench: register and external access sequences for the local bus controller
`default_nettype none
module cslbc_ctrl_tb
  import cslbc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 0, rst = 1, reg_sel = 0, reg_wr = 0, xs_req = 0, xs_wr = 0;
  logic [11:0] reg_addr = 12'h0;
  logic [31:0] reg_wdata = 32'h0, xs_wdata = 32'h0, rd_val = 32'h1234_5678;
  logic [2:0]  xs_cs = 3'h0;
  logic [24:0] xs_addr = 25'h155_1234;
  logic [3:0]  xs_be = 4'h0;
  logic [7:0]  ack_at = 8'h0;
  logic [31:0] reg_rdata, xs_rdata, ad_in, ad_out, ad_oe, cap_a, cap_d, cap_oe, rd;
  logic [5:0]  cs_n;
  logic        reg_ack, xs_ack, core_transfer_error_ack, bus_busy, read_write_n, ale_n;
  logic        transfer_start_strobe_n, ack_n, viol_irq, cap_rw, err;
  int          checks = 0, n_mismatch = 0, n_cs = 0, n_ale = 0;
  cslbc_ctrl dut_u (.clock, .rst, .reg_sel, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
    .reg_ack, .xs_req, .xs_cs, .xs_wr, .xs_addr, .xs_be, .xs_wdata, .xs_rdata, .xs_ack,
    .core_transfer_error_ack, .ad_in, .ad_out, .ad_oe, .bus_busy, .cs_n, .read_write_n,
    .ale_n, .transfer_start_strobe_n, .ack_n, .viol_irq);
  cslbc_periph per_u (.clock, .cs_n, .read_write_n, .ad_out, .ad_oe, .rd_val, .ack_at,
    .ad_in, .ack_n);
  initial forever #12.5ns clock = ~clock;
  // Bus monitor: what the pins showed in strobe and select clocks
  always @(posedge clock) begin
    if (!ale_n) begin
      n_ale++;
      cap_a = ad_out;
    end
    if (cs_n != 6'h3f) begin
      n_cs++;
      cap_d = ad_out;
      cap_oe = ad_oe;
      cap_rw = read_write_n;
    end
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Bounded wait for an answer pulse
  task automatic wv(ref logic s);
    for (int i = 0; i < 600 && s !== 1'b1; i++) @(negedge clock);
    if (s !== 1'b1) begin
      n_mismatch++;
      test_done();
    end
  endtask
  task automatic rg(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(negedge clock);
    reg_sel = 1;
    reg_wr = w;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clock);
    wv(reg_ack);
    rd = reg_rdata;
    reg_sel = 0;
  endtask
  task automatic xa(input logic [2:0] c, input logic w, input logic [3:0] be,
                    input logic [31:0] d);
    @(negedge clock);
    n_cs = 0;
    n_ale = 0;
    xs_req = 1;
    xs_cs = c;
    xs_wr = w;
    xs_be = be;
    xs_wdata = d;
    @(negedge clock);
    wv(xs_ack);
    rd = xs_rdata;
    err = core_transfer_error_ack;
    xs_req = 0;
  endtask
  // Config word: waits, mode, ack, 25-bit address, size, bank 2, type, swap, read-only
  function automatic logic [31:0] cf(input logic mx, aa, rs, ro, input logic [1:0] ds, wt,
                                     input logic [7:0] wx, wp);
    return {wp, wx, mx, 1'b0, aa, 1'b1, 2'h3, ds, 2'h2, wt, 1'b0, rs, 1'b0, ro};
  endfunction
  initial begin
    repeat (2) @(negedge clock);
    rst = 0;
    rg(0, CSLBC_OFS_BOOT, 0);
    chk(rd, 32'h0000_1001);
    rg(0, CSLBC_OFS_CFG1, 0);
    chk(rd, 32'h0);
    rg(0, 12'h320, 0);
    chk(rd, 32'h0);
    rg(1, CSLBC_OFS_CTRL, 32'h0100_0101);
    $display("test registers done");
    // Every wait type, both directions: WaitX 2, WaitP 1, joined 258
    for (int t = 0; t < 4; t++) begin
      rg(1, CSLBC_OFS_CFG1, cf(1, 0, 0, 0, 2'h3, 2'(t), 8'h02, 8'h01));
      for (int w = 0; w < 2; w++) begin
        xa(3'h1, w[0], 4'hf, 32'hc3a5_5a3c);
        chk(n_cs, (t == 3 || (w == 1 && t == 2)) ? 258 : (w == 1 && t == 1) ? 1 : 2);
        chk(n_ale, 1);
        chk(cap_a, 32'h4555_1234);
        chk(cap_rw, w == 0);
        chk(w == 1 ? cap_d : rd, w == 1 ? 32'hc3a5_5a3c : 32'h1234_5678);
        chk(w == 1 ? 32'h0 : cap_oe, 32'h0);
      end
    end
    $display("test wait types done");
    // Long strobe, read swap on, write swap off
    rg(1, CSLBC_OFS_CFG1, cf(1, 0, 1, 0, 2'h3, 2'h0, 8'h03, 8'h0) | 32'h0000_4000);
    xa(3'h1, 0, 4'hf, 0);
    chk(rd, 32'h7856_3412);
    chk(n_ale, 2);
    xa(3'h1, 1, 4'hf, 32'h1122_3344);
    chk(cap_d, 32'h1122_3344);
    // One-byte port: size codes, idle lanes driven low
    rg(1, CSLBC_OFS_CFG1, cf(1, 0, 0, 0, 2'h0, 2'h0, 8'h02, 8'h0));
    xa(3'h1, 1, 4'h1, 32'h0000_00ab);
    chk(cap_a & 32'h7000_0000, 32'h1000_0000);
    chk(cap_d, 32'h0000_00ab);
    chk(cap_oe, 32'hffff_ffff);
    xa(3'h1, 0, 4'h3, 0);
    chk(cap_a & 32'h7000_0000, 32'h2000_0000);
    chk(cap_oe, 32'hffff_ff00);
    $display("test swap and size done");
    // Acknowledge shortens only when honoured
    ack_at = 8'h4;
    rg(1, CSLBC_OFS_CFG1, cf(1, 1, 0, 0, 2'h3, 2'h0, 8'h1e, 8'h0));
    xa(3'h1, 0, 4'hf, 0);
    chk(32'(n_cs < 30), 32'h1);
    rg(1, CSLBC_OFS_CFG1, cf(1, 0, 0, 0, 2'h3, 2'h0, 8'h1e, 8'h0));
    xa(3'h1, 0, 4'hf, 0);
    chk(n_cs, 30);
    ack_at = 8'h0;
    // Forbidden directions stay off the pins and flag; a disabled select stays off the pins without error
    rg(1, CSLBC_OFS_CFG1, cf(1, 0, 0, 1, 2'h3, 2'h0, 8'h02, 8'h0));
    xa(3'h1, 1, 4'hf, 0);
    chk(n_cs + n_ale, 32'h0);
    chk(err, 1);
    chk(viol_irq, 1);
    rg(0, CSLBC_OFS_STAT, 0);
    chk(rd & 32'h0100_0000, 32'h0100_0000);
    rg(1, CSLBC_OFS_STAT, 32'h0100_0000);
    chk(viol_irq, 0);
    rg(1, CSLBC_OFS_CFG1, cf(1, 0, 0, 0, 2'h3, 2'h0, 8'h02, 8'h0) | 32'h2);
    xa(3'h1, 0, 4'hf, 0);
    chk(n_cs + n_ale, 32'h0);
    chk(err, 1);
    xa(3'h2, 0, 4'hf, 0);
    chk(n_cs + n_ale, 32'h0);
    chk(err, 0);
    $display("test ack and refusal done");
    // Single tenure: 16-bit address low, 16-bit data high
    rg(1, CSLBC_OFS_CFG1, cf(0, 0, 0, 0, 2'h1, 2'h0, 8'h03, 8'h0) & 32'hffff_f7ff);
    xa(3'h1, 1, 4'h3, 32'h0000_beef);
    chk(cap_d, 32'hbeef_1234);
    chk(n_ale + n_cs, 3);
    $display("test single tenure done");
    test_done();
  end
endmodule
`default_nettype wire
